// >>> hw/gpio_port_pkg.sv
`default_nettype none
package gpio_port_pkg;
	localparam int          NPINS     = 8;
	localparam int          ADDR_W    = 12;
	localparam int          DATA_W    = 32;
	// register byte offsets
	localparam logic [11:0] OFF_DATA  = 12'h000;
	localparam logic [11:0] OFF_DIR   = 12'h004;
	localparam logic [11:0] OFF_PULL  = 12'h008;
	localparam logic [11:0] OFF_CTRL  = 12'h00c;
	// reset values
	localparam logic [7:0]  DATA_RST  = 8'h00;
	localparam logic [7:0]  DIR_RST   = 8'h00;
	localparam logic [7:0]  PULL_RST  = 8'h00;
	localparam logic [5:0]  CTRL_RST  = 6'h00;
	// pull-up implemented on pins 0,1,3,4,7 only
	localparam logic [7:0]  PULL_IMPL = 8'h9b;
	// control register fields
	localparam int          CTRL_W    = 6;
	localparam int          C_SPL     = 0;
	localparam int          C_LCD_PORT_INPUT_CTRL   = 1;
	localparam int          C_SEG31   = 2;
	localparam int          C_SEG30   = 3;
	localparam int          C_IRQ0    = 4;
	localparam int          C_IRQ4    = 5;
	// pins shared with lcd segments and wake-up interrupts
	localparam int          PIN_SEG31 = 5;
	localparam int          PIN_SEG30 = 6;
	localparam int          PIN_IRQ0  = 0;
	localparam int          PIN_IRQ4  = 4;

	typedef enum logic [1:0] {
		ST_SETUP  = 2'b01,
		ST_ACCESS = 2'b10
	} apb_state_t;

	typedef struct packed {
		logic [NPINS-1:0] o;
		logic [NPINS-1:0] oe;
	} pin_drive_t;
endpackage
`default_nettype wire

// >>> hw/gpio_port.sv
`default_nettype none
// Functional notes
// RL1 - direction one makes pin an output
// RL2 - output pin shows data latch value
// RL3 - writes always load latch
// RL4 - read returns latch for output pins
// RL5 - direction zero: pin not driven
// RL6 - input read returns pin; rmw returns latch
// RL7 - peripheral output read returns pin level
// RL8 - peripheral input read returns pin level
// RL9 - software clears segment bits, sets lcd_port_input_ctrl
// RL10 - segment bit hands pin to lcd
// RL11 - software clears direction before lcd use
// RL12 - reset clears all direction bits
// RL13 - standby with spl: hi-z, inputs low
// RL14 - pins 0,4 stay open if irq enabled
// RL15 - standby without spl keeps pin states
// RL16 - pull-up on unless pin drives low
// RL17 - open-drain high releases pin
// RL18 - software disables peripheral output first
// RL19 - bit n controls pin n; pull-ups 2,5,6 absent
// RL20 - absent pull-up bits read zero
module gpio_port
	import gpio_port_pkg::*;
#(
	parameter logic [NPINS-1:0] OD_MASK = 8'h00
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output var  logic [DATA_W-1:0] prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              rmw_read,
	input  wire logic              standby_mode,
	input  wire logic [NPINS-1:0]  pin_i,
	output var  logic [NPINS-1:0]  pin_o,
	output var  logic [NPINS-1:0]  pin_oe,
	output var  logic [NPINS-1:0]  pin_pullup,
	input  wire logic [NPINS-1:0]  periph_o,
	input  wire logic [NPINS-1:0]  periph_oe,
	input  wire logic [1:0]        lcd_seg_o,
	output var  logic [NPINS-1:0]  pin_to_periph
);
	initial begin
		if (NPINS != 8)
			$error("gpio_port serves eight pins only");
	end

	logic [NPINS-1:0]  latch_q;
	logic [NPINS-1:0]  dir_q;
	logic [NPINS-1:0]  pull_q;
	logic [CTRL_W-1:0] ctrl_q;
	apb_state_t        state_q;
	apb_state_t        state_d;
	logic [NPINS-1:0]  sync1_q;
	logic [NPINS-1:0]  pin_s_q;
	pin_drive_t        drive_d;
	pin_drive_t        drive_q;

	// pin input synchroniser; first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 8'h00;
			pin_s_q <= 8'h00;
		end else begin
			sync1_q <= pin_i;
			pin_s_q <= sync1_q;
		end
	end

	// bus decode
	wire setup_ph  = psel && !penable;
	wire access_ph = psel && penable && pready;
	wire mapped    = (paddr == OFF_DATA) || (paddr == OFF_DIR)
	               || (paddr == OFF_PULL) || (paddr == OFF_CTRL);
	wire wr_en     = access_ph && pwrite && mapped;
	wire wr_data   = wr_en && (paddr == OFF_DATA);
	wire wr_dir    = wr_en && (paddr == OFF_DIR);
	wire wr_pull   = wr_en && (paddr == OFF_PULL);
	wire wr_ctrl   = wr_en && (paddr == OFF_CTRL);

	// pin ownership
	wire              standby_pin_state_bit      = ctrl_q[C_SPL];
	wire              hiz      = standby_mode && standby_pin_state_bit;
	wire [NPINS-1:0]  seg_mask = {1'b0, ctrl_q[C_SEG30], ctrl_q[C_SEG31], 5'h00};
	wire [NPINS-1:0]  per_own  = periph_oe & ~seg_mask;
	wire [NPINS-1:0]  port_out = dir_q & ~per_own & ~seg_mask;
	wire [NPINS-1:0]  port_in  = ~dir_q & ~per_own & ~seg_mask;
	wire [NPINS-1:0]  irq_keep = {3'h0, ctrl_q[C_IRQ4], 3'h0, ctrl_q[C_IRQ0]};

	// data read: latch for port outputs and rmw, pin level otherwise
	wire [NPINS-1:0]  data_rd  = rmw_read ? latch_q
	                           : ((latch_q & port_out) | (pin_s_q & ~port_out)); // see RL4 see RL6 see RL7 see RL8
	wire [DATA_W-1:0] rdata    =
		(paddr == OFF_DATA) ? {24'h000000, data_rd} :
		(paddr == OFF_DIR)  ? {24'h000000, dir_q} :
		(paddr == OFF_PULL) ? {24'h000000, pull_q} :
		(paddr == OFF_CTRL) ? {26'h0000000, ctrl_q} : 32'h00000000;

	// per-pin drive selection
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			logic seg_o;
			if (gi == PIN_SEG31) begin : g_s31
				assign seg_o = lcd_seg_o[0];
			end else if (gi == PIN_SEG30) begin : g_s30
				assign seg_o = lcd_seg_o[1];
			end else begin : g_ns
				assign seg_o = 1'b0;
			end
			always_comb begin
				drive_d.o[gi]  = 1'b0;
				drive_d.oe[gi] = 1'b0;
				if (hiz) begin
					drive_d.oe[gi] = 1'b0; // see RL13
				end else if (seg_mask[gi]) begin
					drive_d.o[gi]  = seg_o; // see RL10
					drive_d.oe[gi] = 1'b1;
				end else if (per_own[gi]) begin
					drive_d.o[gi]  = periph_o[gi];
					drive_d.oe[gi] = 1'b1;
				end else if (dir_q[gi]) begin
					// open-drain high floats instead of driving
					drive_d.o[gi]  = OD_MASK[gi] ? 1'b0 : latch_q[gi]; // see RL17
					drive_d.oe[gi] = OD_MASK[gi] ? !latch_q[gi] : 1'b1; // see RL1 see RL2
				end else begin
					drive_d.oe[gi] = 1'b0; // see RL5
				end
			end
		end
	endgenerate

	// pull-up cut while the pin itself drives low
	wire [NPINS-1:0] low_drv = drive_d.oe & ~drive_d.o;
	wire [NPINS-1:0] pull_d  = pull_q & PULL_IMPL & ~low_drv; // see RL16 see RL19
	// standby input gating: blocked inputs read low
	wire [NPINS-1:0] in_d    = hiz ? (pin_s_q & irq_keep) : pin_s_q; // see RL13 see RL14

	always_comb begin
		state_d = ST_SETUP;
		case (state_q)
			ST_SETUP:  state_d = setup_ph ? ST_ACCESS : ST_SETUP;
			ST_ACCESS: state_d = ST_SETUP;
			default:   state_d = ST_SETUP;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_SETUP;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			state_q <= state_d;
			pready  <= (state_d == ST_ACCESS);
			pslverr <= setup_ph && !mapped;
			if (setup_ph && !pwrite)
				prdata <= rdata;
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= DATA_RST;
			dir_q   <= DIR_RST; // see RL12
			pull_q  <= PULL_RST; // see RL20
			ctrl_q  <= CTRL_RST;
		end else begin
			if (wr_data)
				latch_q <= pwdata[7:0]; // see RL3
			if (wr_dir)
				dir_q <= pwdata[7:0]; // see RL19
			if (wr_pull)
				pull_q <= pwdata[7:0] & PULL_IMPL; // see RL20
			if (wr_ctrl)
				ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end

	// pin outputs; with spl low standby changes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_q       <= '0;
			pin_pullup    <= 8'h00;
			pin_to_periph <= 8'h00;
		end else begin
			drive_q       <= drive_d; // see RL15
			pin_pullup    <= pull_d;
			pin_to_periph <= in_d;
		end
	end

	assign pin_o  = drive_q.o;
	assign pin_oe = drive_q.oe;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence data_write_s;
		psel && penable && pready && pwrite && (paddr == OFF_DATA);
	endsequence
	sequence data_read_s(bit rmw);
		setup_ph && !pwrite && (paddr == OFF_DATA) && (rmw_read == rmw);
	endsequence
	sequence dir_write_s;
		psel && penable && pready && pwrite && (paddr == OFF_DIR);
	endsequence
	sequence pull_write_s;
		psel && penable && pready && pwrite && (paddr == OFF_PULL);
	endsequence
	sequence ctrl_write_s;
		psel && penable && pready && pwrite && (paddr == OFF_CTRL);
	endsequence

	// bus timing: exactly one wait-free access cycle per transfer
	access_next_a: assert property (setup_ph |=> pready) // see RL3
		else $error("no access cycle after setup");
	access_pulse_a: assert property (pready |=> !pready) // see RL3
		else $error("ready held past access");
	unmapped_err_a: assert property (setup_ph && !mapped |=> pslverr)
		else $error("unmapped address not refused");
	unmapped_rd_a: assert property (setup_ph && !mapped && !pwrite |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	mapped_ok_a: assert property (setup_ph && mapped |=> !pslverr)
		else $error("mapped address refused");

	// register writes land once, and only when addressed
	dir_write_a: assert property (dir_write_s |=> dir_q == $past(pwdata[7:0])) // see RL19
		else $error("direction write not taken");
	pull_write_a: assert property (pull_write_s |=> // see RL20
		pull_q == ($past(pwdata[7:0]) & PULL_IMPL))
		else $error("pull-up write mask wrong");
	ctrl_write_a: assert property (ctrl_write_s |=> ctrl_q == $past(pwdata[CTRL_W-1:0]))
		else $error("control write not taken");
	dir_hold_a: assert property (!wr_dir |=> $stable(dir_q)) // see RL1
		else $error("direction changed without write");
	latch_hold_a: assert property (!wr_data |=> $stable(latch_q)) // see RL3
		else $error("latch changed without write");

	// pin ownership and standby behaviour
	periph_drive_a: assert property (!hiz && per_own != 8'h00 |=> // see RL7
		(pin_oe & $past(per_own)) == $past(per_own)
		&& ((pin_o ^ $past(periph_o)) & $past(per_own)) == 8'h00)
		else $error("peripheral output not on pin");
	seg30_owner_a: assert property (ctrl_q[C_SEG30] && !hiz |=> pin_oe[PIN_SEG30] // see RL10
		&& pin_o[PIN_SEG30] == $past(lcd_seg_o[1]))
		else $error("second segment pin not handed over");
	standby_keep_a: assert property (standby_mode && !standby_pin_state_bit |=> // see RL15
		(pin_oe & $past(port_out & ~OD_MASK)) == $past(port_out & ~OD_MASK))
		else $error("standby without pin-state bit released pins");
	input_path_a: assert property (!hiz |=> pin_to_periph == $past(pin_s_q)) // see RL8
		else $error("input path not following pin");
	irq4_keep_a: assert property (hiz && ctrl_q[C_IRQ4] |=> // see RL14
		pin_to_periph[PIN_IRQ4] == $past(pin_s_q[PIN_IRQ4]))
		else $error("second wake-up input blocked");

	port_drive_a: assert property (!hiz |=> // see RL1
		((pin_o ^ $past(latch_q)) & $past(port_out) & ~OD_MASK) == 8'h00
		&& (pin_oe & $past(port_out) & ~OD_MASK) == ($past(port_out) & ~OD_MASK))
		else $error("port output not following latch");
	input_float_a: assert property (1'b1 |=> (pin_oe & $past(port_in)) == 8'h00) // see RL5
		else $error("input pin driven");
	latch_write_a: assert property (data_write_s |=> latch_q == $past(pwdata[7:0])) // see RL3
		else $error("data write not latched");
	plain_read_a: assert property (data_read_s(1'b0) ##1 pready |-> // see RL6
		prdata[7:0] == ($past(latch_q & port_out) | $past(pin_s_q & ~port_out)))
		else $error("ordinary read value wrong");
	rmw_read_a: assert property (data_read_s(1'b1) |=> pready && prdata[7:0] == $past(latch_q)) // see RL6
		else $error("rmw read not latch");
	standby_hiz_a: assert property (hiz |=> pin_oe == 8'h00 // see RL13
		&& (pin_to_periph & ~$past(irq_keep)) == 8'h00)
		else $error("standby pins not released");
	irq_keep_a: assert property (hiz && ctrl_q[C_IRQ0] |=> // see RL14
		pin_to_periph[PIN_IRQ0] == $past(pin_s_q[PIN_IRQ0]))
		else $error("wake-up input blocked");
	pullup_cut_a: assert property (1'b1 |=> (pin_pullup & ~PULL_IMPL) == 8'h00 // see RL16
		&& (pin_pullup & pin_oe & ~pin_o) == 8'h00)
		else $error("pull-up on a low pin");
	seg_owner_a: assert property (ctrl_q[C_SEG31] && !hiz |=> pin_oe[PIN_SEG31] // see RL10
		&& pin_o[PIN_SEG31] == $past(lcd_seg_o[0]))
		else $error("segment pin not handed over");
	od_release_a: assert property (!hiz && (port_out & OD_MASK & latch_q) != 8'h00 |=> // see RL17
		(pin_oe & $past(port_out & OD_MASK & latch_q)) == 8'h00)
		else $error("open-drain pin driven high");
endmodule
`default_nettype wire

// >>> bench/pin_model.sv
`default_nettype none
module pin_model (
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic       ext_en,
	output var  logic [7:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last = 8'h00;
	always @* begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				last[i] = pin_o[i];
			else if (ext_en)
				last[i] = ext_val[i];
		end
	end
	// a floating pin reads high if its pull-up is on, otherwise the inverse of its last level
	always_comb begin
		for (int i = 0; i < 8; i++)
			pin_i[i] = pin_oe[i] ? pin_o[i] : ext_en ? ext_val[i] : pin_pullup[i] | ~last[i];
	end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench;
	import gpio_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] OD = 8'h80;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        rmw_read = 0, standby_mode = 0, ext_en = 1, err, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0]  pin_i, pin_o, pin_oe, pin_pullup, pin_to_periph, l, d, p, lv;
	logic [7:0]  periph_o = 0, periph_oe = 0, ext_val = 0;
	logic [1:0]  lcd_seg_o = 0;
	int          failures = 0, checks_done = 0;

	always #25 pclk = ~pclk;

	gpio_port #(.OD_MASK(OD)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rmw_read, .standby_mode, .pin_i, .pin_o,
		.pin_oe, .pin_pullup, .periph_o, .periph_oe, .lcd_seg_o, .pin_to_periph);
	pin_model i_pins (.pin_o, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_i);

	function automatic logic [7:0] e_oe(input logic [7:0] d, p, l);
		return p | (d & ~OD) | (d & OD & ~l);
	endfunction
	// open-drain pins only ever pull low, unless a peripheral owns them and drives periph_o
	function automatic logic [7:0] e_o(input logic [7:0] d, p, l, po);
		return (p & po) | (~p & d & ~OD & l);
	endfunction

	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt,
		input logic m);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		rmw_read <= m;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// look between edges: these values stand at the next rising edge
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		if (n >= 20) failures++;
		psel <= 1'b0;
		penable <= 1'b0;
		rmw_read <= 1'b0;
	endtask

	task automatic settle;
		repeat (5) @(posedge pclk);
	endtask

	task automatic test_done;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#500us;
		failures++;
		test_done;
	end

	initial begin
		void'($urandom(32'hda669aa3));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFF_DIR, 0, 0); chk(rd, 0);
		apb(0, OFF_PULL, 0, 0); chk(rd, 0);
		apb(0, 12'h010, 0, 0); chk(rd, 0);
		chk(32'(err), 1);
		apb(1, OFF_PULL, 32'hff, 0);
		apb(0, OFF_PULL, 0, 0); chk(rd, 32'h9b);
		for (int k = 0; k < 24; k++) begin
			l = $urandom;
			d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
			p = (k < 8) ? 8'h00 : 8'($urandom);
			periph_oe <= p;
			periph_o <= $urandom;
			ext_val <= $urandom;
			apb(1, OFF_DATA, 32'(l), 0);
			apb(1, OFF_DIR, 32'(d), 0);
			settle;
			lv = e_o(d, p, l, periph_o) | (~e_oe(d, p, l) & ext_val);
			chk(pin_oe, e_oe(d, p, l));
			chk(pin_o & pin_oe, e_o(d, p, l, periph_o));
			chk(pin_pullup, 8'h9b & ~(e_oe(d, p, l) & ~e_o(d, p, l, periph_o)));
			chk(pin_to_periph, lv);
			apb(0, OFF_DATA, 0, 0); chk(rd, 32'((l & d & ~p) | (lv & ~(d & ~p))));
			apb(0, OFF_DATA, 0, 1); chk(rd, 32'(l));
		end
		periph_oe <= 8'h00;
		lcd_seg_o <= $urandom;
		apb(1, OFF_DIR, 0, 0);
		apb(1, OFF_CTRL, 32'h0e, 0);
		settle;
		chk(pin_oe & 8'h60, 8'h60);
		chk(pin_o[6:5], lcd_seg_o);
		apb(1, OFF_DIR, 32'h0f, 0);
		apb(1, OFF_CTRL, 32'h31, 0);
		standby_mode <= 1'b1;
		settle;
		chk(pin_oe, 0);
		chk(pin_to_periph, ext_val & 8'h11);
		apb(1, OFF_CTRL, 32'h30, 0);
		settle;
		chk(pin_oe, e_oe(8'h0f, 8'h00, l));
		standby_mode <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFF_DIR, 0, 0); chk(rd, 0);
		test_done;
	end
endmodule
`default_nettype wire
